// *** src/icam_regs.v ***
// Initial channel mask register bank with APB slave and CSR load path
//
// Functional notes
// - Hardware or software reset sets masks all ones
// - Serial-bus reset leaves both mask registers unchanged
// - Any reset event copies upper mask to CSR
// - Any reset event copies lower mask to CSR
`timescale 1ns/100ps
`default_nettype none
`include "icam_defines.vh"

module icam_regs #(
  parameter AW = 12,
  parameter CW = 8
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output wire          pready,
  output reg           pslverr,
  // Reset event levels, active high
  input  wire          global_reset_input,
  input  wire          host_bus_reset_input,
  input  wire          serial_bus_reset,
  // Bus-management channels-available CSR load path
  output reg  [31:0]   csr_chan_avail_upper,
  output reg  [31:0]   csr_chan_avail_lower,
  output reg           csr_chan_avail_load
);

  // Register index decode, used for reads and writes
  localparam SEL_NONE  = 4'b0000;
  localparam SEL_UPPER = 4'b0001;
  localparam SEL_LOWER = 4'b0010;
  localparam SEL_CTRL  = 4'b0100;
  localparam SEL_STAT  = 4'b1000;

  function [3:0] icam_decode;
    input [AW-1:0] addr;
    begin
      case (addr)
        `ICAM_OFS_MASK_UPPER: icam_decode = SEL_UPPER;
        `ICAM_OFS_MASK_LOWER: icam_decode = SEL_LOWER;
        `ICAM_OFS_CONTROL:    icam_decode = SEL_CTRL;
        `ICAM_OFS_STATUS:     icam_decode = SEL_STAT;
        default:              icam_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge of write data into an old value
  function [31:0] icam_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer k;
    begin
      icam_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          icam_merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  reg  [31:0]                  initial_channel_mask_upper;
  reg  [31:0]                  initial_channel_mask_lower;
  reg  [`ICAM_NUM_CAUSES-1:0]  last_cause;
  reg  [CW-1:0]                load_count;
  wire [`ICAM_NUM_CAUSES-1:0]  event_pulse;
  wire [3:0]                   sel;
  wire                         setup_phase;
  wire                         write_access;
  wire                         soft_reset;
  wire                         load_event;
  reg  [31:0]                  next_prdata;
  reg                          next_pslverr;

  // Edge detection of the three reset sources
  icam_reset_event #(
    .N (`ICAM_NUM_CAUSES)
  ) u_event (
    .pclk       (pclk),
    .presetn    (presetn),
    .level_in   ({serial_bus_reset, host_bus_reset_input,
                  global_reset_input}),
    .edge_pulse (event_pulse)
  );

  // Bus phase qualifiers; every access completes with no wait state
  assign sel          = icam_decode(paddr);
  assign setup_phase  = psel & ~penable;
  assign write_access = psel & penable & pwrite & ~pslverr;
  assign pready       = 1'b1;
  assign soft_reset   = write_access & sel[2] & pstrb[0] &
                        pwdata[`ICAM_CTRL_SOFT_RESET];
  assign load_event   = |event_pulse;

  // Mask registers: reset to all ones, untouched by bus-reset events
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      initial_channel_mask_upper <= `ICAM_MASK_RESET;
      initial_channel_mask_lower <= `ICAM_MASK_RESET;
    end else if (soft_reset) begin
      initial_channel_mask_upper <= `ICAM_MASK_RESET;
      initial_channel_mask_lower <= `ICAM_MASK_RESET;
    end else if (write_access) begin
      // No reset event touches these, only writes do
      if (sel[0]) begin
        initial_channel_mask_upper <= icam_merge(
          initial_channel_mask_upper, pwdata, pstrb);
      end
      if (sel[1]) begin
        initial_channel_mask_lower <= icam_merge(
          initial_channel_mask_lower, pwdata, pstrb);
      end
    end
  end

  // Copy of both masks into the CSR pair on any reset event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_chan_avail_upper <= `ICAM_MASK_RESET;
      csr_chan_avail_lower <= `ICAM_MASK_RESET;
      csr_chan_avail_load  <= 1'b0;
    end else begin
      csr_chan_avail_load <= load_event;
      if (load_event) begin
        csr_chan_avail_upper <= initial_channel_mask_upper;
        csr_chan_avail_lower <= initial_channel_mask_lower;
      end
    end
  end

  // Status: cause of the last load and a wrapping load count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cause <= {`ICAM_NUM_CAUSES{1'b0}};
      load_count <= {CW{1'b0}};
    end else if (load_event) begin
      last_cause <= event_pulse;
      load_count <= load_count + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Read data and error chosen in the setup cycle
  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (sel)
      SEL_UPPER: next_prdata = initial_channel_mask_upper;
      SEL_LOWER: next_prdata = initial_channel_mask_lower;
      SEL_CTRL:  next_prdata = 32'h0000_0000;
      SEL_STAT: begin
        next_prdata[`ICAM_STAT_CAUSE_MSB:`ICAM_STAT_CAUSE_LSB] =
          last_cause;
        next_prdata[`ICAM_STAT_COUNT_MSB:`ICAM_STAT_COUNT_LSB] =
          load_count;
      end
      default:   next_pslverr = 1'b1;
    endcase
    if (pwrite && sel == SEL_STAT) begin
      next_pslverr = 1'b1; // Status is read-only
    end
  end

  // Registered read data, stable through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule // icam_regs

`default_nettype wire

// *** pkg/icam_defines.vh ***
// Register map, reset values and field positions of the channel mask bank
`ifndef ICAM_DEFINES_VH
`define ICAM_DEFINES_VH

// Byte offsets on the register bus
`define ICAM_OFS_MASK_UPPER   12'h0B4
`define ICAM_OFS_MASK_LOWER   12'h0B8
`define ICAM_OFS_CONTROL      12'h0C0
`define ICAM_OFS_STATUS       12'h0C4

// Reset value of both mask registers
`define ICAM_MASK_RESET       32'hFFFF_FFFF

// Control register fields
`define ICAM_CTRL_SOFT_RESET  0

// Status register fields
`define ICAM_STAT_CAUSE_LSB   0
`define ICAM_STAT_CAUSE_MSB   2
`define ICAM_STAT_COUNT_LSB   8
`define ICAM_STAT_COUNT_MSB   15

// Load causes, one bit per source
`define ICAM_CAUSE_GLOBAL     0
`define ICAM_CAUSE_HOST_BUS   1
`define ICAM_CAUSE_SERIAL_BUS 2
`define ICAM_NUM_CAUSES       3

`endif

// *** src/icam_reset_event.v ***
// Rising-edge detectors turning reset levels into one-cycle load pulses
`timescale 1ns/100ps
`default_nettype none

module icam_reset_event #(
  parameter N = 3
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Reset levels, active high
  input  wire [N-1:0] level_in,
  // One-cycle pulse on each rising edge
  output wire [N-1:0] edge_pulse
);

  reg [N-1:0] level_prev;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_edge
      // Previous level; zero so a level high at release counts as an edge
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_prev[i] <= 1'b0;
        end else begin
          level_prev[i] <= level_in[i];
        end
      end
      assign edge_pulse[i] = level_in[i] & ~level_prev[i];
    end
  endgenerate

endmodule // icam_reset_event

`default_nettype wire

// *** sim/icam_regs_monitor.sv ***
// Port assertions for the channel mask bank
`timescale 1ns/100ps
`default_nettype none
module icam_regs_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Reset event levels
  input wire logic        global_reset_input,
  input wire logic        host_bus_reset_input,
  input wire logic        serial_bus_reset,
  // CSR load path
  input wire logic [31:0] csr_chan_avail_upper,
  input wire logic [31:0] csr_chan_avail_lower,
  input wire logic        csr_chan_avail_load
);
  // Event levels as one vector
  wire [2:0] ev = {serial_bus_reset, host_bus_reset_input,
                   global_reset_input};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pair is all ones while reset holds
  chk_reset_all_ones: assert property (disable iff (1'b0)
    !presetn |-> &{csr_chan_avail_upper, csr_chan_avail_lower})
    else $error("csr pair not all ones in reset");
  // Any rising event gives a load
  chk_event_loads: assert property ($rose(ev[0]) ||
    $rose(ev[1]) || $rose(ev[2]) |=> csr_chan_avail_load)
    else $error("event gave no load");
  // A load needs an event level
  chk_load_cause: assert property (
    csr_chan_avail_load |-> |$past(ev))
    else $error("load without event");
  // Pair changes only with a load
  chk_pair_holds: assert property (presetn && !csr_chan_avail_load |->
    $stable(csr_chan_avail_upper) && $stable(csr_chan_avail_lower))
    else $error("csr pair moved without load");
  // Steady levels give no load
  chk_level_once: assert property (
    ev == $past(ev) && $past(presetn) |=> !csr_chan_avail_load)
    else $error("load from held level");
endmodule // icam_regs_monitor
bind icam_regs icam_regs_monitor i_icam_regs_monitor (.pclk(pclk),
  .presetn(presetn), .global_reset_input(global_reset_input),
  .host_bus_reset_input(host_bus_reset_input),
  .serial_bus_reset(serial_bus_reset),
  .csr_chan_avail_upper(csr_chan_avail_upper),
  .csr_chan_avail_lower(csr_chan_avail_lower),
  .csr_chan_avail_load(csr_chan_avail_load));
`default_nettype wire

// *** sim/initial_channel_availability_regs_tb.sv ***
// Self-checking bench for the channel mask bank
`timescale 1ns/100ps
`default_nettype none
module initial_channel_availability_regs_tb;
  logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, cu, cl, q, eu, el, d;
  logic [3:0]  pstrb = 4'hf, st;
  logic [2:0]  ev = 0, lc = 0;
  logic        pready, pslverr, ld, pe;
  int          n_errors = 0, comparisons = 0, cyc = 0, i, n, nl = 0;
  // Device under test
  icam_regs i_icam_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_reset_input(ev[0]), .host_bus_reset_input(ev[1]),
    .serial_bus_reset(ev[2]), .csr_chan_avail_upper(cu),
    .csr_chan_avail_lower(cl), .csr_chan_avail_load(ld));
  // Clock and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (++cyc > 4000) begin
    n_errors++;
    wrap_up;
  end
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Byte-lane merge of a write
  function [31:0] mrg(input [31:0] o, input [31:0] w, input [3:0] s);
    for (int k = 0; k < 4; k++) if (s[k]) o[8*k+:8] = w[8*k+:8];
    return o;
  endfunction
  // One APB transfer, read data into q
  task xfer(input w, input [11:0] a, input [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    q = prdata;
    pe = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Raise event levels and check the copied pair
  task fire(input [2:0] e);
    ev <= e;
    nl++;
    lc = e;
    for (n = 0; n < 4 && ld !== 1; n++) @(posedge pclk);
    chk(ld, 1);
    chk(cu, eu);
    chk(cl, el);
    ev <= 0;
  endtask
  // Main sequence
  initial begin
    presetn <= 0;
    d = $urandom(32'h21fb);
    eu = 32'hffff_ffff;
    el = eu;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 12; i++) begin
      if (i == 6) begin
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        nl = 0;
        lc = 0;
        eu = 32'hffff_ffff;
        el = eu;
      end
      if (i == 9) begin
        pstrb <= 4'hf;
        xfer(1, 12'h0c0, 32'h0000_0001);
        eu = 32'hffff_ffff;
        el = eu;
      end
      xfer(0, 12'h0b4, 0);
      chk(q, eu);
      chk(pe, 0);
      xfer(0, 12'h0b8, 0);
      chk(q, el);
      chk(pe, 0);
      st = (i < 2) ? 4'hf : 4'($urandom);
      pstrb <= st;
      d = $urandom;
      xfer(1, 12'h0b4, d);
      eu = mrg(eu, d, st);
      d = $urandom;
      xfer(1, 12'h0b8, d);
      el = mrg(el, d, st);
      fire(3'b001 << (i % 3));
    end
    xfer(0, 12'h0bc, 0);
    chk(q, 0);
    chk(pe, 1);
    // Status is read-only: write refused, then cause and count
    xfer(1, 12'h0c4, 32'hffff_ffff);
    chk(pe, 1);
    xfer(0, 12'h0c4, 0);
    chk(q, {16'h0000, nl[7:0], 5'h00, lc});
    chk(pe, 0);
    // Control reads back zero
    xfer(0, 12'h0c0, 0);
    chk(q, 0);
    chk(pe, 0);
    wrap_up;
  end
  // Verdict and end of run
  task wrap_up;
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule // initial_channel_availability_regs_tb
`default_nettype wire
